// file: design/rsw_reset_ctrl.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rsw_reset_ctrl
  import rsw_pkg::*;
#(
  parameter int WARMUP_CYCLES = WARMUP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic EXT_RESET_N,
  input wire logic WDT_OVF_REQ,
  input wire logic CLK_FAULT_REQ,
  input wire logic VD1_REQ,
  input wire logic VD2_REQ,
  input wire logic TRIM_FAULT_REQ,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic CPU_RESET,
  output logic PERIPH_RESET,
  output logic WARMUP_ACTIVE,
  output logic CPU_HOLD,
  output logic VECTOR_FETCH,
  output logic [15:0] PC_INIT,
  output logic [15:0] VECTOR_HI_ADDR,
  output logic [15:0] SP_INIT,
  output logic RBS_INIT,
  output logic INT_CLEAR,
  output logic HF_OSC_FORCE_ON,
  output logic LF_OSC_FORCE_OFF,
  output logic TG_CLEAR,
  output logic WDT_ENABLE,
  output logic VD_INIT,
  output logic EXT_RESET_DISABLED,
  output logic VECTOR_AREA,
  output logic VECTOR_RELOCATE,
  output logic [TRIM_WORDS*TRIM_W-1:0] TRIM_DATA,
  output logic TRIM_ABNORMAL
);
  localparam logic [CNT_W-1:0] WCNT_LAST = CNT_W'(WARMUP_CYCLES - 1);

  // Reset pin synchroniser with agreement filter
  logic ext_s1_q, ext_s2_q, ext_s3_q, ext_low_q;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ext_s1_q <= 1'h1;
      ext_s2_q <= 1'h1;
      ext_s3_q <= 1'h1;
      ext_low_q <= 1'h0;
    end else begin
      ext_s1_q <= EXT_RESET_N;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_low_q <= ~ext_s2_q;
      end
    end
  end

  // Reset request combination
  logic edis_q;
  wire ext_eff = ext_low_q & ~edis_q;
  wire int_req = WDT_OVF_REQ | CLK_FAULT_REQ | VD1_REQ | VD2_REQ | TRIM_FAULT_REQ;
  wire sys_req = ext_eff | int_req;

  // Write channel state
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [2:0] pend_q;
  logic [1:0] vect_q;
  logic cause_flag_clear_q;
  logic [NFLAGS-1:0] flags_q;

  // Write decode
  wire aw_hs = S_AXI_AWVALID & awready_q;
  wire w_hs = S_AXI_WVALID & wready_q;
  wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  wire lane0 = do_wr & wstrb_q[0];
  wire hit_pend = waddr_q == ADDR_PEND;
  wire hit_flags = waddr_q == ADDR_FLAGS;
  wire hit_key = waddr_q == ADDR_KEY;
  wire wr_hit = hit_pend | hit_flags | hit_key;
  wire wr_pend = lane0 & hit_pend;
  wire wr_flags = lane0 & hit_flags;
  wire wr_key = lane0 & hit_key;
  wire [7:0] key = wdata_q[7:0];
  wire key_edis = wr_key & (key == KEY_EDIS);
  wire key_vect = wr_key & (key == KEY_VECT);
  wire key_cause_flag_clear = wr_key & (key == KEY_CAUSE_FLAG_CLEAR) & cause_flag_clear_q;

  // Address and data capture
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      aw_hold_q <= 1'h0;
      awready_q <= 1'h1;
      waddr_q <= 16'h0000;
    end else if (aw_hs) begin
      aw_hold_q <= 1'h1;
      awready_q <= 1'h0;
      waddr_q <= S_AXI_AWADDR;
    end else if (bvalid_q & S_AXI_BREADY) begin
      aw_hold_q <= 1'h0;
      awready_q <= 1'h1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      w_hold_q <= 1'h0;
      wready_q <= 1'h1;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (w_hs) begin
      w_hold_q <= 1'h1;
      wready_q <= 1'h0;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end else if (bvalid_q & S_AXI_BREADY) begin
      w_hold_q <= 1'h0;
      wready_q <= 1'h1;
    end
  end

  // Write response
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'h1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'h0;
    end
  end

  // Read decode
  logic arready_q, rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  wire ar_hs = S_AXI_ARVALID & arready_q;
  wire rd_pend = S_AXI_ARADDR == ADDR_PEND;
  wire rd_flags = S_AXI_ARADDR == ADDR_FLAGS;
  wire rd_stat = S_AXI_ARADDR == ADDR_STATUS;
  wire rd_hit = rd_pend | rd_flags | rd_stat;
  wire [DATA_W-1:0] rd_word = rd_pend ? {29'h0, pend_q} :
                              rd_flags ? {26'h0, flags_q} :
                              rd_stat ? {29'h0, vect_q[1], vect_q[0], edis_q} : 32'h0;

  // Read channel
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      arready_q <= 1'h1;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_q & S_AXI_RREADY) begin
      arready_q <= 1'h1;
      rvalid_q <= 1'h0;
    end
  end

  // Pending copy and active settings
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_q <= PEND_RST;
      vect_q <= 2'h0;
    end else if (sys_req) begin
      pend_q <= PEND_RST;
      vect_q <= 2'h0;
    end else begin
      if (wr_pend) begin
        pend_q <= wdata_q[2:0];
      end
      if (key_vect) begin
        vect_q <= pend_q[B_RELOC:B_AREA];
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      edis_q <= 1'h0;
    end else if (key_edis) begin
      edis_q <= pend_q[B_EDIS];
    end
  end

  // Flag-clear arm bit, self-clearing
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cause_flag_clear_q <= 1'h0;
    end else if (sys_req | key_cause_flag_clear) begin
      cause_flag_clear_q <= 1'h0;
    end else if (wr_flags) begin
      cause_flag_clear_q <= wdata_q[B_CAUSE_FLAG_CLEAR];
    end
  end

  // Trim load bookkeeping
  logic [TIDX_W-1:0] tidx_q;
  logic trd_q;
  logic [TRIM_AW-1:0] taddr_q;
  logic [TRIM_W-1:0] trim_word;
  logic [TRIM_WORDS*TRIM_W-1:0] trim_q;
  rsw_st_e st_q, st_d;
  wire trd_en = (st_q == ST_WARM) & ~sys_req & (tidx_q < TIDX_W'(TRIM_WORDS));
  wire trim_bad = trd_q & (^trim_word);

  // Cause flag sources
  wire [NFLAGS-1:0] flag_set = {trim_bad, TRIM_FAULT_REQ, VD2_REQ, VD1_REQ,
                                CLK_FAULT_REQ, WDT_OVF_REQ};
  // clear on pin reset or key
  wire flag_clr = ext_eff | key_cause_flag_clear;

  genvar gi;
  generate
    for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
      always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          flags_q[gi] <= FLAGS_RST[gi];
        end else begin
          flags_q[gi] <= flag_set[gi] | (flags_q[gi] & ~flag_clr);
        end
      end
    end
  endgenerate

  // Sequencer next state
  logic [CNT_W-1:0] wcnt_q, wcnt_d;
  always_comb begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    case (st_q)
      ST_RESET: begin
        wcnt_d = '0;
        if (!sys_req) begin
          st_d = ST_WARM;
        end
      end
      ST_WARM: begin
        if (sys_req) begin
          st_d = ST_RESET;
          wcnt_d = '0;
        end else if (wcnt_q == WCNT_LAST) begin
          st_d = ST_FETCH;
        end else begin
          wcnt_d = wcnt_q + 1'b1;
        end
      end
      ST_FETCH: begin
        st_d = sys_req ? ST_RESET : ST_RUN;
      end
      ST_RUN: begin
        if (sys_req) begin
          st_d = ST_RESET;
        end
      end
      default: begin
        st_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_RESET;
      wcnt_q <= '0;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
    end
  end

  // Trim index and read tracking
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tidx_q <= '0;
      trd_q <= 1'h0;
      taddr_q <= '0;
    end else begin
      trd_q <= trd_en;
      taddr_q <= tidx_q[TRIM_AW-1:0];
      if (st_q == ST_RESET) begin
        tidx_q <= '0;
      end else if (trd_en) begin
        tidx_q <= tidx_q + 1'b1;
      end
    end
  end

  rsw_trim_mem u_trim (
    .clk(SYS_CLK),
    .rst(RST),
    .rd_en(trd_en),
    .addr(tidx_q[TRIM_AW-1:0]),
    .rdata_q(trim_word)
  );

  generate
    for (gi = 0; gi < TRIM_WORDS; gi++) begin : g_trim
      always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          trim_q[gi*TRIM_W +: TRIM_W] <= 8'h00;
        end else if (trd_q && taddr_q == TRIM_AW'(gi)) begin
          trim_q[gi*TRIM_W +: TRIM_W] <= trim_word;
        end
      end
    end
  endgenerate

  // Registered sequence outputs
  logic cpu_rst_q, warm_q, hold_q, vfetch_q, wdt_q, vd_init_q;
  logic [15:0] pc_q, vhi_q, sp_q;
  logic rbs_q;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cpu_rst_q <= 1'h1;
      warm_q <= 1'h0;
      hold_q <= 1'h1;
      vfetch_q <= 1'h0;
      wdt_q <= 1'h0;
      vd_init_q <= 1'h1;
    end else begin
      cpu_rst_q <= st_d == ST_RESET;
      warm_q <= st_d == ST_WARM;
      hold_q <= st_d != ST_RUN;
      vfetch_q <= st_d == ST_FETCH;
      wdt_q <= (st_d == ST_FETCH) | (st_d == ST_RUN);
      vd_init_q <= ext_eff;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pc_q <= RST_VECTOR;
      vhi_q <= RST_VECTOR_HI;
      sp_q <= SP_RESET_VAL;
      rbs_q <= RBS_RESET_VAL;
    end else begin
      pc_q <= RST_VECTOR;
      vhi_q <= RST_VECTOR_HI;
      sp_q <= SP_RESET_VAL;
      rbs_q <= RBS_RESET_VAL;
    end
  end

  // Port mapping
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign CPU_RESET = cpu_rst_q;
  assign PERIPH_RESET = cpu_rst_q;
  assign WARMUP_ACTIVE = warm_q;
  assign CPU_HOLD = hold_q;
  assign VECTOR_FETCH = vfetch_q;
  assign PC_INIT = pc_q;
  assign VECTOR_HI_ADDR = vhi_q;
  assign SP_INIT = sp_q;
  assign RBS_INIT = rbs_q;
  assign INT_CLEAR = hold_q;
  assign HF_OSC_FORCE_ON = hold_q;
  assign LF_OSC_FORCE_OFF = hold_q;
  assign TG_CLEAR = hold_q;
  assign WDT_ENABLE = wdt_q;
  assign VD_INIT = vd_init_q;
  assign EXT_RESET_DISABLED = edis_q;
  assign VECTOR_AREA = vect_q[0];
  assign VECTOR_RELOCATE = vect_q[1];
  assign TRIM_DATA = trim_q;
  assign TRIM_ABNORMAL = flags_q[F_TRMBAD];

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  status_zero_a: assert property (
    ar_hs && rd_stat |=> rvalid_q && rdata_q[7:3] == 5'h0)
    else $error("status upper bits not zero");
  flags_zero_a: assert property (
    ar_hs && rd_flags |=> rdata_q[7:6] == 2'h0 && rdata_q[5:0] == $past(flags_q))
    else $error("flag register read wrong");
  pend_clear_a: assert property (
    sys_req |=> pend_q == PEND_RST)
    else $error("pending copy kept over reset");
  wdt_flag_a: assert property (
    WDT_OVF_REQ |=> flags_q[F_WDT])
    else $error("watchdog flag not set");
  clkf_flag_a: assert property (
    CLK_FAULT_REQ |=> flags_q[F_CLKF])
    else $error("clock fault flag not set");
  flag_keep_a: assert property (
    int_req && !ext_eff && !do_wr && flags_q[F_VD1] |=> flags_q[F_VD1])
    else $error("flag lost on internal reset");
  key_clear_a: assert property (
    key_cause_flag_clear && !int_req && !ext_eff && !trim_bad |=> flags_q == '0 && !cause_flag_clear_q)
    else $error("key did not clear flags");
  hold_rst_a: assert property (
    sys_req |=> cpu_rst_q && hold_q && !wdt_q)
    else $error("reset not held");
  warm_restart_a: assert property (
    st_q == ST_WARM && sys_req |=> st_q == ST_RESET && wcnt_q == '0)
    else $error("warm-up not restarted");
  fetch_end_a: assert property (
    st_q == ST_WARM && !sys_req && wcnt_q == WCNT_LAST
    |=> vfetch_q && pc_q == RST_VECTOR ##1 !vfetch_q)
    else $error("vector fetch missing");
  wdt_on_a: assert property (
    $rose(wdt_q) |-> vfetch_q && hold_q)
    else $error("watchdog enabled early");

  warm_done_c: cover property (st_q == ST_WARM ##1 st_q == ST_FETCH ##1 st_q == ST_RUN);
  key_clear_c: cover property (key_cause_flag_clear);
  warm_abort_c: cover property (st_q == ST_WARM && sys_req);
  edis_c: cover property (key_edis && pend_q[B_EDIS]);
endmodule
`default_nettype wire

// file: design/rsw_trim_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_trim_mem
  import rsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic [TRIM_AW-1:0] addr,
  output logic [TRIM_W-1:0] rdata_q
);
  // Fixed trim contents, even parity per word
  logic [TRIM_W-1:0] word;
  always_comb begin
    case (addr)
      2'h0: word = 8'h03;
      2'h1: word = 8'h05;
      2'h2: word = 8'h06;
      default: word = 8'h09;
    endcase
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      rdata_q <= word;
    end
  end
endmodule
`default_nettype wire

// file: include/rsw_pkg.sv
`default_nettype none
package rsw_pkg;
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // Register indexes and byte addresses
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 16'h0fcc;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 16'h0fdf;
  localparam logic [ADDR_W-1:0] IDX_KEY = 16'h0fdf;
  localparam logic [ADDR_W-1:0] IDX_PEND = 16'h0fde;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'(IDX_FLAGS * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_KEY = ADDR_W'(IDX_KEY * 4);
  localparam logic [ADDR_W-1:0] ADDR_PEND = ADDR_W'(IDX_PEND * 4);
  // Key codes
  localparam logic [7:0] KEY_EDIS = 8'hb2;
  localparam logic [7:0] KEY_VECT = 8'hd4;
  localparam logic [7:0] KEY_CAUSE_FLAG_CLEAR = 8'h71;
  // Field positions
  localparam int B_EDIS = 0;
  localparam int B_AREA = 1;
  localparam int B_RELOC = 2;
  localparam int B_CAUSE_FLAG_CLEAR = 7;
  localparam int F_WDT = 0;
  localparam int F_CLKF = 1;
  localparam int F_VD1 = 2;
  localparam int F_VD2 = 3;
  localparam int F_TRMRST = 4;
  localparam int F_TRMBAD = 5;
  localparam int NFLAGS = 6;
  // Reset values
  localparam logic [2:0] PEND_RST = 3'h0;
  localparam logic [NFLAGS-1:0] FLAGS_RST = 6'h00;
  localparam logic [15:0] RST_VECTOR = 16'hfffe;
  localparam logic [15:0] RST_VECTOR_HI = 16'hffff;
  localparam logic [15:0] SP_RESET_VAL = 16'h00ff;
  localparam logic RBS_RESET_VAL = 1'h0;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARMUP_TIME_US = 1000;
  localparam int WARMUP_CYC = (WARMUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  // Trim store
  localparam int TRIM_WORDS = 4;
  localparam int TRIM_AW = 2;
  localparam int TRIM_W = 8;
  localparam int TIDX_W = 3;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_WARM = 4'h2,
    ST_FETCH = 4'h4,
    ST_RUN = 4'h8
  } rsw_st_e;
endpackage
`default_nettype wire

// file: test/test_reset_status_and_warmup_release.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_status_and_warmup_release
  import rsw_pkg::*;
();
  localparam int WARM = 16;
  typedef struct {string nm; logic [33:0] v;} rsw_exp_s;
  logic sys_clk = 1'b0;
  logic rst, ext_n, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] reqs;
  logic [15:0] awaddr, araddr, pc, vhi, sp;
  logic [31:0] wdata, rdata, trim;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, cpu_reset, periph_reset, warm, cpu_hold;
  logic vfetch, register_bank_select, int_clr, hf_on, lf_off, tg_clr, wdt_en, vd_init, edis, varea, vreloc;
  logic trim_bad;
  logic [7:0] k;
  logic [3:0] wstrb;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 17;
  rsw_exp_s wq[$];
  rsw_exp_s rq[$];
  rsw_exp_s e;

  // Free-running system clock
  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  rsw_reset_ctrl #(.WARMUP_CYCLES(WARM)) i_rsw_reset_ctrl (
    .SYS_CLK(sys_clk), .RST(rst), .EXT_RESET_N(ext_n),
    .WDT_OVF_REQ(reqs[0]), .CLK_FAULT_REQ(reqs[1]), .VD1_REQ(reqs[2]),
    .VD2_REQ(reqs[3]), .TRIM_FAULT_REQ(reqs[4]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CPU_RESET(cpu_reset), .PERIPH_RESET(periph_reset), .WARMUP_ACTIVE(warm),
    .CPU_HOLD(cpu_hold), .VECTOR_FETCH(vfetch), .PC_INIT(pc), .VECTOR_HI_ADDR(vhi),
    .SP_INIT(sp), .RBS_INIT(register_bank_select), .INT_CLEAR(int_clr), .HF_OSC_FORCE_ON(hf_on),
    .LF_OSC_FORCE_OFF(lf_off), .TG_CLEAR(tg_clr), .WDT_ENABLE(wdt_en), .VD_INIT(vd_init),
    .EXT_RESET_DISABLED(edis), .VECTOR_AREA(varea), .VECTOR_RELOCATE(vreloc),
    .TRIM_DATA(trim), .TRIM_ABNORMAL(trim_bad)
  );

  task automatic chk(input string nm, input logic [33:0] x, input logic [33:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    wq.push_back('{"bresp", {r, 32'h0}});
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // Bus read: expectation queued for the monitor
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [1:0] r,
                    input string nm);
    rq.push_back('{nm, {r, x}});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Monitor takes the oldest note at each response handshake
  always @(posedge sys_clk) begin
    if (bvalid && bready) begin
      e = wq.pop_front();
      chk(e.nm, e.v, {bresp, 32'h0});
    end
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk(e.nm, e.v, {rresp, rdata});
    end
  end

  // Internal reset request held for a few cycles
  task automatic pulse(input int i);
    @(posedge sys_clk);
    reqs[i] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("held", 34'h1c, 34'({cpu_reset, periph_reset, cpu_hold, wdt_en, vd_init}));
    @(posedge sys_clk);
    reqs[i] <= 1'b0;
  endtask

  task automatic pin(input logic x);
    @(posedge sys_clk);
    ext_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("pin reset", 34'({x, x}), 34'({cpu_reset, vd_init}));
    @(posedge sys_clk);
    ext_n <= 1'b1;
  endtask

  // Count warm-up cycles up to the vector fetch, then check forced state
  task automatic run();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      if (warm) n++;
    end while (!vfetch);
    chk("warmup", 34'(WARM), 34'(n));
    chk("vector", 34'({16'hfffe, 16'hffff}), 34'({pc, vhi}));
    chk("stack", 34'({16'h00ff, 1'b0}), 34'({sp, register_bank_select}));
    chk("forced", 34'h3f, 34'({wdt_en, cpu_hold, int_clr, hf_on, lf_off, tg_clr}));
    @(posedge sys_clk);
    #1;
    chk("release", 34'h1, 34'({cpu_hold, wdt_en}));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    ext_n = 1'b1;
    reqs = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    run();
    chk("trim", 34'h09060503, 34'(trim));
    chk("trim state", 34'h0, 34'(trim_bad));
    rd(ADDR_STATUS, 32'h0, RESP_OKAY, "status");
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY, "flags");
    rd(16'h0004, 32'h0, RESP_DECERR, "unmapped");
    wr(16'h0004, 8'($random(seed)), RESP_DECERR);
    $display("test boot finished");
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      run();
      rd(ADDR_FLAGS, 32'((2 << i) - 1), RESP_OKAY, "cause flags");
    end
    $display("test causes finished");
    pulse(2);
    repeat (5) @(posedge sys_clk);
    pulse(3);
    run();
    $display("test restart finished");
    wr(ADDR_KEY, KEY_CAUSE_FLAG_CLEAR, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h1f, RESP_OKAY, "unarmed key");
    wr(ADDR_FLAGS, 8'h80, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h1f, RESP_OKAY, "armed flags");
    k = 8'($random(seed));
    if (k == KEY_EDIS || k == KEY_VECT || k == KEY_CAUSE_FLAG_CLEAR) k = k ^ 8'h01;
    wr(ADDR_KEY, k, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h1f, RESP_OKAY, "odd key");
    wr(ADDR_KEY, KEY_CAUSE_FLAG_CLEAR, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY, "cleared flags");
    $display("test clear finished");
    // Write without the low byte lane leaves the register alone
    wstrb <= 4'he;
    wr(ADDR_PEND, 8'h07, RESP_OKAY);
    rd(ADDR_PEND, 32'h0, RESP_OKAY, "masked write");
    wstrb <= 4'hf;
    wr(ADDR_PEND, 8'h07, RESP_OKAY);
    rd(ADDR_PEND, 32'h7, RESP_OKAY, "pending copy");
    rd(ADDR_STATUS, 32'h0, RESP_OKAY, "status pending");
    wr(ADDR_KEY, KEY_VECT, RESP_OKAY);
    rd(ADDR_STATUS, 32'h6, RESP_OKAY, "status vector");
    wr(ADDR_KEY, KEY_EDIS, RESP_OKAY);
    rd(ADDR_STATUS, 32'h7, RESP_OKAY, "status disable");
    chk("active", 34'h7, 34'({vreloc, varea, edis}));
    pin(1'b0);
    pulse(0);
    run();
    rd(ADDR_STATUS, 32'h1, RESP_OKAY, "disable kept");
    wr(ADDR_KEY, KEY_EDIS, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY, "pending lost");
    rd(ADDR_FLAGS, 32'h1, RESP_OKAY, "flag kept");
    pin(1'b1);
    run();
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY, "pin clears");
    $display("test config finished");
    wr(ADDR_PEND, 8'h01, RESP_OKAY);
    wr(ADDR_KEY, KEY_EDIS, RESP_OKAY);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY, "disable set");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    run();
    rd(ADDR_STATUS, 32'h0, RESP_OKAY, "power clears");
    $display("test power finished");
    give_verdict();
  end
endmodule
`default_nettype wire
